// file: core/amsfc_core.sv
// amplifier strap decode, sync rate derivation and fault control
// assumes synchronous inputs, a strap converter giving one valid strobe,
// and an external pull-up on the open-drain fault line
//
// Overview of operation
// - strap level decoded into 3-bit word at start-up
// - word captured once, held until power cycle
// - 8/16/32/48/96/192 kHz give 96 kHz sync
// - 11.025/22.05/44.1/88.2 kHz give 88.2 kHz sync
// - switching rate is 4,5,6,8 times sync
// - 3.11 to 6.6 V selects 26 dBV
// - 0 to 3.1 V selects 20 dBV
// - overcurrent pulls fault low, outputs high-Z
// - overcurrent retries after clear interval
// - DC offset pulls fault low, latched
// - mute line toggle clears DC offset latch
// - stopped audio clock resets until restart
// - analog supply monitor only when enabled
module amsfc_core
    import amsfc_pkg::*;
#(
    parameter int OC_CLEAR_CYC = OC_CLEAR_CYC_DEF
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // strap converter
    input wire logic i_strap_valid,
    input wire logic [12:0] i_strap_mv,
    // audio clocks and rate
    input wire logic [3:0] i_fs_code,
    input wire logic i_mclk,
    input wire logic i_bclk,
    input wire logic i_frame_select_clock,
    // fault sources and controls
    input wire logic i_overcurrent_error,
    input wire logic i_dc_offset,
    input wire logic i_mute_line_in,
    input wire logic i_analog_uv_monitor_enable,
    input wire logic i_analog_supply_low,
    // open-drain fault pin
    input wire logic i_fault_out_n,
    output logic o_fault_out_n,
    output logic o_fault_out_n_oe,
    // status and output stage
    output logic o_speaker_outputs_en,
    output logic [2:0] o_strap_word,
    output logic o_strap_reserved,
    output logic o_gain_26db,
    output logic [3:0] o_switch_mult,
    output logic o_sync_882,
    output logic o_sync_tick,
    output logic o_switch_tick,
    output logic o_clock_error,
    output logic o_analog_uv_fault,
    output logic o_fault_line_low
);

    localparam int OC_W = $clog2(OC_CLEAR_CYC + 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    amsfc_state_t state, next_state;
    logic [2:0] strap_word;
    logic strap_rsv;
    logic oc_active, next_oc_active;
    logic [OC_W-1:0] oc_cnt, next_oc_cnt;
    logic dc_latch, next_dc_latch;
    logic mute_prev;
    logic [CLK_STOP_W-1:0] low_cnt [3];
    logic spk_en;
    logic sync_882;

    // ------------------------------------------------------------
    // decode and selection
    // ------------------------------------------------------------
    // band decode
    wire logic [3:0] strap_dec = strap_decode(i_strap_mv);
    wire logic capture = (state == ST_WAIT) && i_strap_valid;
    wire logic [2:0] audio_clk = {i_frame_select_clock, i_bclk, i_mclk};
    wire logic [2:0] clk_stopped;
    wire logic clk_err = |clk_stopped;
    wire logic mute_toggle = (i_mute_line_in != mute_prev);
    wire logic rate_ok = fs_valid(i_fs_code);
    wire logic uv_fault = i_analog_uv_monitor_enable && i_analog_supply_low;
    wire logic oc_done = (oc_cnt == OC_W'(OC_CLEAR_CYC - 1));
    wire logic run = (state == ST_RUN);
    wire logic sync_en = run && rate_ok;
    wire logic [TICK_W-1:0] sync_per = sync_period(sync_882);
    wire logic [TICK_W-1:0] sw_per = switch_period(sync_882, strap_word[1:0]);

    // start-up sequence: wait for one conversion, then run for good
    always_comb begin
        next_state = state;
        case (state)
            ST_WAIT: if (i_strap_valid) next_state = ST_RUN;
            ST_RUN: next_state = ST_RUN;
            default: next_state = ST_WAIT;
        endcase
    end

    // overcurrent: new event restarts the interval, then retry
    always_comb begin
        next_oc_active = oc_active;
        next_oc_cnt = oc_cnt;
        if (i_overcurrent_error) begin
            next_oc_active = 1'b1;
            next_oc_cnt = '0;
        end else if (clk_err) begin
            next_oc_active = 1'b0;
            next_oc_cnt = '0;
        end else if (oc_active) begin
            next_oc_active = !oc_done;
            next_oc_cnt = oc_done ? '0 : oc_cnt + OC_W'(1);
        end
    end

    // latch, mute toggle or clock error clears, set wins
    assign next_dc_latch = i_dc_offset || (dc_latch && !mute_toggle && !clk_err);

    // stopped-clock detection per audio clock
    generate
        for (genvar g = 0; g < 3; g++) begin : g_stop
            assign clk_stopped[g] = (low_cnt[g] == CLK_STOP_W'(CLK_STOP_CYC));
        end
    endgenerate

    // low-time counters, one process so each counter has a single driver
    always_ff @(posedge i_clk) begin
        for (int k = 0; k < 3; k++) begin
            if (i_rst || audio_clk[k]) low_cnt[k] <= '0;
            else if (!clk_stopped[k]) low_cnt[k] <= low_cnt[k] + CLK_STOP_W'(1);
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // strap word held once captured
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= ST_WAIT;
            strap_word <= STRAP_WORD_RST;
            strap_rsv <= 1'b0;
        end else begin
            state <= next_state;
            if (capture) begin
                strap_word <= strap_dec[2:0];
                strap_rsv <= strap_dec[3];
            end
        end
    end

    // fault state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            oc_active <= 1'b0;
            oc_cnt <= '0;
            dc_latch <= 1'b0;
            mute_prev <= 1'b0;
        end else begin
            oc_active <= next_oc_active;
            oc_cnt <= next_oc_cnt;
            dc_latch <= next_dc_latch;
            mute_prev <= i_mute_line_in;
        end
    end

    // output stage enable, follows faults in the same edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            spk_en <= 1'b0;
            sync_882 <= 1'b0;
        end else begin
            spk_en <= (next_state == ST_RUN) && !strap_rsv && !capture_rsv()
                      && !next_oc_active && !next_dc_latch && !clk_err
                      && !uv_fault && rate_ok;
            // 96 kHz family, 88.2 kHz family
            sync_882 <= fs_is_882(i_fs_code);
        end
    end

    function automatic logic capture_rsv();
        return capture && strap_dec[3];
    endfunction : capture_rsv

    // sync rate divider
    amsfc_tick_div #(.W(TICK_W)) u_sync_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_en(sync_en),
        .i_period(sync_per),
        .o_tick(o_sync_tick)
    );

    // switching rate as multiple of sync
    amsfc_tick_div #(.W(TICK_W)) u_switch_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_en(spk_en),
        .i_period(sw_per),
        .o_tick(o_switch_tick)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // released when no overcurrent or DC offset fault remains
    assign o_fault_out_n_oe = oc_active || dc_latch;
    assign o_fault_out_n = 1'b0;  // only ever drives low
    assign o_fault_line_low = !i_fault_out_n;
    assign o_speaker_outputs_en = spk_en;
    assign o_strap_word = strap_word;
    assign o_strap_reserved = strap_rsv;
    assign o_gain_26db = strap_word[STRAP_GAIN_BIT];
    assign o_switch_mult = 4'(mult_of(strap_word[1:0]));
    assign o_sync_882 = sync_882;
    assign o_clock_error = clk_err;
    assign o_analog_uv_fault = uv_fault;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // sync tick spacing helper
    logic [TICK_W-1:0] sgap;
    logic sgap_ok;
    logic [3:0] fs_prev;
    always_ff @(posedge i_clk) begin
        if (i_rst || !sync_en || i_fs_code != fs_prev) begin
            sgap <= '0;
            sgap_ok <= 1'b0;
        end else if (o_sync_tick) begin
            sgap <= TICK_W'(1);
            sgap_ok <= 1'b1;
        end else begin
            sgap <= sgap + TICK_W'(1);
        end
        fs_prev <= i_fs_code;
    end

    // switch tick spacing helper, restarted on enable loss or rate change
    logic [TICK_W-1:0] wgap;
    logic wgap_ok;
    always_ff @(posedge i_clk) begin
        if (i_rst || !spk_en || i_fs_code != fs_prev) begin
            wgap <= '0;
            wgap_ok <= 1'b0;
        end else if (o_switch_tick) begin
            wgap <= TICK_W'(1);
            wgap_ok <= 1'b1;
        end else begin
            wgap <= wgap + TICK_W'(1);
        end
    end

    strap_capture_a: assert property (capture |=> run && o_strap_word == $past(strap_dec[2:0])
        && o_strap_reserved == $past(strap_dec[3])) else $error("strap word not captured");
    strap_hold_a: assert property (run && $past(run) |-> $stable(o_strap_word)
        && $stable(o_strap_reserved)) else $error("strap word changed after start-up");
    sync_96k_a: assert property (o_sync_tick && sgap_ok && !sync_882
        |-> sgap == TICK_W'(CLK_HZ / SYNC_96_HZ)) else $error("96 kHz sync spacing wrong");
    sync_88k_a: assert property (o_sync_tick && sgap_ok && sync_882
        |-> sgap == TICK_W'(CLK_HZ / SYNC_882_HZ)) else $error("88.2 kHz sync spacing wrong");
    switch_mult_a: assert property (run |-> o_switch_mult inside {4'h4, 4'h5, 4'h6, 4'h8}
        && o_switch_mult == 4'(mult_of(o_strap_word[1:0]))) else $error("bad switch multiple");
    gain_high_a: assert property (capture && i_strap_mv >= STRAP_H4_MV
        && i_strap_mv <= STRAP_H_MAX_MV |=> o_gain_26db && !o_strap_reserved)
        else $error("26 dBV band not selected");
    gain_low_a: assert property (capture && i_strap_mv <= STRAP_L_MAX_MV
        |=> !o_gain_26db && !o_strap_reserved) else $error("20 dBV band not selected");
    reserved_off_a: assert property (o_strap_reserved |-> !o_speaker_outputs_en)
        else $error("outputs enabled on reserved strap");
    oc_fault_a: assert property (i_overcurrent_error |=> o_fault_out_n_oe
        && !o_speaker_outputs_en) else $error("overcurrent not handled");
    oc_retry_a: assert property ($fell(oc_active) |-> $past(clk_err)
        || $past(oc_cnt) == OC_W'(OC_CLEAR_CYC - 1)) else $error("overcurrent retry timing");
    dc_latch_a: assert property (i_dc_offset ##1 (!mute_toggle && !clk_err)[*3]
        |-> o_fault_out_n_oe && !o_speaker_outputs_en) else $error("DC offset not latched");
    dc_clear_a: assert property (dc_latch && mute_toggle && !i_dc_offset
        && !i_overcurrent_error && !oc_active |=> !o_fault_out_n_oe)
        else $error("mute toggle did not clear DC fault");
    clk_stop_a: assert property (clk_err |=> !o_speaker_outputs_en
        && (!dc_latch || $past(i_dc_offset))) else $error("clock error did not reset");
    uv_gate_a: assert property (i_analog_uv_monitor_enable && i_analog_supply_low
        |=> !o_speaker_outputs_en) else $error("monitor fault left outputs enabled");
    fault_release_a: assert property (!oc_active && !dc_latch && !i_overcurrent_error
        && !i_dc_offset |=> !o_fault_out_n_oe) else $error("fault line held with no fault");
    switch_gap_a: assert property (o_switch_tick && wgap_ok
        |-> wgap == TICK_W'(CLK_HZ / ((sync_882 ? SYNC_882_HZ : SYNC_96_HZ)
        * int'(o_switch_mult)))) else $error("switching rate not a multiple of sync");

    oc_retry_c: cover property ($fell(oc_active) && !clk_err);
    dc_clear_c: cover property (dc_latch ##1 !dc_latch && !clk_err);
    clk_err_c: cover property ($rose(clk_err) ##[1:50] !clk_err);
    sync_88k_c: cover property (o_sync_tick && sgap_ok && sync_882);
    reserved_c: cover property (capture && strap_dec[3]);

endmodule : amsfc_core

// file: core/amsfc_pkg.sv
// amplifier strap decode and fault control: shared constants and helpers
// assumes a single 125 MHz clock and a strap level already digitised in mV
package amsfc_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    // overcurrent clear interval, microseconds
    localparam int OC_CLEAR_US = 1000;
    localparam int OC_CLEAR_CYC_DEF = OC_CLEAR_US * CLK_MHZ;
    // audio clock held low this long counts as stopped, microseconds
    localparam int CLK_STOP_US = 10;
    localparam int CLK_STOP_CYC = CLK_STOP_US * CLK_MHZ;
    localparam int CLK_STOP_W = $clog2(CLK_STOP_CYC + 1);

    // ------------------------------------------------------------
    // strap band lower edges and 20/26 dBV band maxima in millivolts
    // ------------------------------------------------------------
    localparam logic [12:0] STRAP_RSV_MV = 13'h19D2;  // 6610
    localparam logic [12:0] STRAP_H8_MV = 13'h1540;   // 5440
    localparam logic [12:0] STRAP_H6_MV = 13'h123E;   // 4670
    localparam logic [12:0] STRAP_H5_MV = 13'h0F32;   // 3890
    localparam logic [12:0] STRAP_H4_MV = 13'h0C26;   // 3110
    localparam logic [12:0] STRAP_L8_MV = 13'h091A;   // 2330
    localparam logic [12:0] STRAP_L6_MV = 13'h0618;   // 1560
    localparam logic [12:0] STRAP_L5_MV = 13'h030C;   // 780
    localparam logic [12:0] STRAP_L_MAX_MV = 13'h0C1C; // 3100
    localparam logic [12:0] STRAP_H_MAX_MV = 13'h19C8; // 6600
    // word: bit 2 gain (1 = 26 dBV), bits 1:0 multiple 4x,5x,6x,8x
    localparam int STRAP_GAIN_BIT = 2;
    localparam logic [2:0] STRAP_WORD_RST = 3'h0;

    // ------------------------------------------------------------
    // sample rate codes and sync rates
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        FS_8K = 4'h0, FS_16K = 4'h1, FS_32K = 4'h2, FS_48K = 4'h3,
        FS_96K = 4'h4, FS_192K = 4'h5, FS_11K025 = 4'h6, FS_22K05 = 4'h7,
        FS_44K1 = 4'h8, FS_88K2 = 4'h9
    } amsfc_fs_t;
    localparam int SYNC_96_HZ = 96_000;
    localparam int SYNC_882_HZ = 88_200;
    localparam int TICK_W = 12;

    typedef enum logic [1:0] {
        ST_WAIT = 2'h0,
        ST_RUN = 2'h1
    } amsfc_state_t;

    // band decode: {reserved, word}
    function automatic logic [3:0] strap_decode(input logic [12:0] mv);
        logic [3:0] r;
        r = 4'h0;
        if (mv >= STRAP_RSV_MV) r = 4'h8;
        else if (mv >= STRAP_H8_MV) r = 4'h7;
        else if (mv >= STRAP_H6_MV) r = 4'h6;
        else if (mv >= STRAP_H5_MV) r = 4'h5;
        else if (mv >= STRAP_H4_MV) r = 4'h4;
        else if (mv >= STRAP_L8_MV) r = 4'h3;
        else if (mv >= STRAP_L6_MV) r = 4'h2;
        else if (mv >= STRAP_L5_MV) r = 4'h1;
        return r;
    endfunction : strap_decode

    function automatic int mult_of(input logic [1:0] sel);
        case (sel)
            2'h0: return 4;
            2'h1: return 5;
            2'h2: return 6;
            default: return 8;
        endcase
    endfunction : mult_of

    function automatic logic fs_is_882(input logic [3:0] fs);
        return (fs >= FS_11K025) && (fs <= FS_88K2);
    endfunction : fs_is_882

    function automatic logic fs_valid(input logic [3:0] fs);
        return fs <= FS_88K2;
    endfunction : fs_valid

    function automatic logic [TICK_W-1:0] sync_period(input logic is882);
        return TICK_W'(CLK_HZ / (is882 ? SYNC_882_HZ : SYNC_96_HZ));
    endfunction : sync_period

    function automatic logic [TICK_W-1:0] switch_period(input logic is882,
                                                       input logic [1:0] sel);
        return TICK_W'(CLK_HZ / ((is882 ? SYNC_882_HZ : SYNC_96_HZ) * mult_of(sel)));
    endfunction : switch_period

endpackage : amsfc_pkg

// file: core/amsfc_tick_div.sv
// one-cycle enable pulse every i_period clocks while enabled
// assumes i_period stays at least 2 and the single system clock
module amsfc_tick_div #(
    parameter int W = 12
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire logic i_en,
    input wire logic [W-1:0] i_period,
    // pulse
    output logic o_tick
);

    logic [W-1:0] cnt;
    wire logic wrap = (cnt >= i_period - W'(1));

    // free count, restarted when disabled
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_en) begin
            cnt <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt <= wrap ? '0 : cnt + W'(1);
            o_tick <= wrap;
        end
    end

endmodule : amsfc_tick_div

// file: tb/amsfc_sysctl_model.sv
// system controller model: pull-up on the fault wire, owner of the mute line
// assumes the design pulls the wire only while its output enable is high
module amsfc_sysctl_model (
    // clock
    input wire logic i_clk,
    // fault wire drive from the design
    input wire logic i_fault_oe,
    input wire logic i_fault_drv,
    // mute toggle request from the bench
    input wire logic i_mute_toggle,
    // resolved wire and mute line
    output logic o_fault_wire,
    output logic o_mute_line_in
);
    timeunit 1ns;
    timeprecision 1ps;

    assign o_fault_wire = i_fault_oe ? i_fault_drv : 1'b1;

    initial o_mute_line_in = 1'b0;

    always @(posedge i_clk) begin
        if (i_mute_toggle) begin
            o_mute_line_in <= ~o_mute_line_in;
        end
    end
endmodule : amsfc_sysctl_model

// file: tb/tb_amp_strap_decode_and_fault_control.sv
// self-checking bench: strap decode, sync rates and fault handling
// assumes the clear interval parameter shortened to a few cycles
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %0t mismatch %0h expected %0h", $time, got, exp); end end

module tb_amp_strap_decode_and_fault_control;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int OC_CYC = 20;
    logic i_clk, i_rst, strap_valid, mclk, bclk, fsclk;
    logic [2:0] stop_clk;
    logic [12:0] strap_mv;
    logic [3:0] fs_code, mult;
    logic oc, dc, uv_en, supply_low, mute_toggle, mute, wire_n;
    logic drv, oe, en, rsv, gain, sync882, sync_tick, sw_tick, clk_err, uv_fault, f_low;
    logic [2:0] word;
    int bad_count = 0;
    int comparisons = 0;

    amsfc_core #(.OC_CLEAR_CYC(OC_CYC)) uut (
        .i_clk(i_clk), .i_rst(i_rst), .i_strap_valid(strap_valid), .i_strap_mv(strap_mv),
        .i_fs_code(fs_code), .i_mclk(mclk), .i_bclk(bclk), .i_frame_select_clock(fsclk),
        .i_overcurrent_error(oc), .i_dc_offset(dc), .i_mute_line_in(mute),
        .i_analog_uv_monitor_enable(uv_en), .i_analog_supply_low(supply_low),
        .i_fault_out_n(wire_n), .o_fault_out_n(drv), .o_fault_out_n_oe(oe),
        .o_speaker_outputs_en(en), .o_strap_word(word), .o_strap_reserved(rsv),
        .o_gain_26db(gain), .o_switch_mult(mult), .o_sync_882(sync882),
        .o_sync_tick(sync_tick), .o_switch_tick(sw_tick), .o_clock_error(clk_err),
        .o_analog_uv_fault(uv_fault), .o_fault_line_low(f_low));

    amsfc_sysctl_model ctl (.i_clk(i_clk), .i_fault_oe(oe), .i_fault_drv(drv),
        .i_mute_toggle(mute_toggle), .o_fault_wire(wire_n), .o_mute_line_in(mute));

    // clock and audio clocks, each audio clock stoppable
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        mclk <= stop_clk[0] ? 1'b0 : ~mclk;
        bclk <= stop_clk[1] ? 1'b0 : ~bclk;
        fsclk <= stop_clk[2] ? 1'b0 : ~fsclk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc
    task automatic look();
        @(negedge i_clk);
    endtask : look
    task automatic do_reset();
        @(posedge i_clk) i_rst <= 1'b1;
        cyc(2);
        i_rst <= 1'b0;
    endtask : do_reset
    task automatic capture(input logic [12:0] mv);
        @(posedge i_clk) begin strap_valid <= 1'b1; strap_mv <= mv; end
        @(posedge i_clk) strap_valid <= 1'b0;
        cyc(2);
        look();
    endtask : capture
    task automatic period_of(input bit sw, output int n);
        int k;
        n = 0;
        for (k = 0; k < 4000 && (sw ? sw_tick : sync_tick) !== 1'b1; k++) look();
        look();
        while (n < 4000 && (sw ? sw_tick : sync_tick) !== 1'b1) begin
            n++;
            look();
        end
        // a tick that never comes ends the run as a mismatch
        if (k >= 4000 || n >= 4000) begin
            bad_count++;
            end_sim();
        end else begin
            n++;
        end
    endtask : period_of
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_bands();
        int mv_tab[11] = '{0, 779, 780, 1560, 2330, 3100, 3110, 3890, 4670, 5440, 6600};
        logic [2:0] w_tab[11] = '{0, 0, 1, 2, 3, 3, 4, 5, 6, 7, 7};
        logic [3:0] m;
        for (int i = 0; i < 11; i++) begin
            do_reset();
            capture(13'(mv_tab[i]));
            m = (w_tab[i][1:0] == 2'h3) ? 4'h8 : 4'(4 + w_tab[i][1:0]);
            `CHK(word, w_tab[i])
            `CHK(gain, w_tab[i][2])
            `CHK(mult, m)
            `CHK(en, 1'b1)
        end
        do_reset();
        capture(13'h19D2);
        `CHK(rsv, 1'b1)
        `CHK(en, 1'b0)
        capture(13'h0100);
        `CHK(rsv, 1'b1)
        `CHK(en, 1'b0)
        do_reset();
        capture(13'h0FA0);
        capture(13'h0064);
        `CHK(word, 3'h5)
    endtask : t_bands

    task automatic t_rates();
        int n;
        for (int c = 0; c < 10; c++) begin
            @(posedge i_clk) fs_code <= 4'(c);
            cyc(2);
            look();
            `CHK(sync882, c >= 6)
        end
        @(posedge i_clk) fs_code <= 4'hA;
        cyc(3);
        look();
        `CHK(en, 1'b0)
        @(posedge i_clk) fs_code <= 4'h3;
        cyc(3);
        period_of(1'b0, n);
        `CHK(n, 125_000_000 / 96_000)
        period_of(1'b1, n);
        `CHK(n, 125_000_000 / (96_000 * 5))
        @(posedge i_clk) fs_code <= 4'h8;
        cyc(3);
        period_of(1'b0, n);
        `CHK(n, 125_000_000 / 88_200)
        period_of(1'b1, n);
        `CHK(n, 125_000_000 / (88_200 * 5))
    endtask : t_rates

    task automatic t_overcurrent();
        @(posedge i_clk) oc <= 1'b1;
        @(posedge i_clk) oc <= 1'b0;
        look();
        `CHK(oe, 1'b1)
        `CHK(drv, 1'b0)
        `CHK(f_low, 1'b1)
        `CHK(en, 1'b0)
        cyc(OC_CYC - 1);
        look();
        `CHK(oe, 1'b1)
        cyc(1);
        look();
        `CHK(oe, 1'b0)
        `CHK(en, 1'b1)
        `CHK(f_low, 1'b0)
    endtask : t_overcurrent

    task automatic t_dc_offset();
        @(posedge i_clk) dc <= 1'b1;
        @(posedge i_clk) dc <= 1'b0;
        look();
        `CHK(oe, 1'b1)
        cyc(OC_CYC * 2);
        look();
        `CHK(oe, 1'b1)
        `CHK(en, 1'b0)
        @(posedge i_clk) mute_toggle <= 1'b1;
        @(posedge i_clk) mute_toggle <= 1'b0;
        cyc(3);
        look();
        `CHK(oe, 1'b0)
        `CHK(en, 1'b1)
    endtask : t_dc_offset

    task automatic t_clock_stop();
        // master, bit and frame clock stopped in turn
        for (int g = 0; g < 3; g++) begin
            @(posedge i_clk) dc <= 1'b1;
            @(posedge i_clk) begin dc <= 1'b0; stop_clk <= 3'h1 << g; end
            cyc(1260);
            look();
            `CHK(clk_err, 1'b1)
            `CHK(en, 1'b0)
            @(posedge i_clk) stop_clk <= 3'h0;
            cyc(4);
            look();
            `CHK(clk_err, 1'b0)
            `CHK(oe, 1'b0)
            `CHK(en, 1'b1)
        end
    endtask : t_clock_stop

    task automatic t_uv_monitor();
        @(posedge i_clk) supply_low <= 1'b1;
        cyc(3);
        look();
        `CHK(uv_fault, 1'b0)
        `CHK(en, 1'b1)
        @(posedge i_clk) uv_en <= 1'b1;
        cyc(2);
        look();
        `CHK(uv_fault, 1'b1)
        `CHK(en, 1'b0)
        @(posedge i_clk) supply_low <= 1'b0;
        cyc(3);
        look();
        `CHK(en, 1'b1)
    endtask : t_uv_monitor

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        i_rst = 1'b1;
        {strap_valid, mclk, bclk, fsclk, stop_clk, oc, dc, uv_en, supply_low} = '0;
        mute_toggle = 1'b0;
        strap_mv = 13'h0000;
        fs_code = 4'h3;
        cyc(2);
        i_rst <= 1'b0;
        t_bands();
        t_rates();
        t_overcurrent();
        t_dc_offset();
        t_clock_stop();
        t_uv_monitor();
        end_sim();
    end
    initial begin
        repeat (100000) @(posedge i_clk);
        bad_count++;
        end_sim();
    end
endmodule : tb_amp_strap_decode_and_fault_control
